// ==== core/eep_defs.vh ====
// Shared constants for the serial memory slave interface.
// Assumes a 10 MHz core clock and the two-wire bus at the pins.
`ifndef EEP_DEFS_VH
`define EEP_DEFS_VH

// Timing
`define EEP_CLK_KHZ 10000
`define EEP_PROG_TIME_MS 10

// Slave address byte layout
`define EEP_TYPE_CODE 4'ha
`define EEP_TYPE_MSB 7
`define EEP_TYPE_LSB 4
`define EEP_SEL_MSB 3
`define EEP_SEL_LSB 1
`define EEP_RW_BIT 0

// Byte framing
`define EEP_BYTE_BITS 4'h8
`define EEP_CNT_ZERO 4'h0
`define EEP_MSB 7

// Array
`define EEP_ADDR_W 13
`define EEP_FULL_ADDR_W 16

// Slave states
`define EEP_ST_IDLE 3'h0
`define EEP_ST_DEVADDR 3'h1
`define EEP_ST_ADDR_HI 3'h2
`define EEP_ST_ADDR_LO 3'h3
`define EEP_ST_WDATA 3'h4
`define EEP_ST_READ 3'h5
`define EEP_ST_WAITSTOP 3'h6

`endif

// ==== core/eep_bus_sync.v ====
// Pin synchroniser and bus condition detector.
// Assumes scl_in and sda_in are asynchronous to mclk.
`timescale 1ns/10ps
module eep_bus_sync (
    input wire mclk,
    input wire reset_n,
    input wire scl_in,
    input wire sda_in,
    output wire scl_s,
    output wire sda_s,
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det
);
    reg scl_meta_reg;
    reg sda_meta_reg;
    reg scl_sync_reg;
    reg sda_sync_reg;
    reg scl_prev_reg;
    reg sda_prev_reg;

    // Two stages, then one history stage for edges
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            scl_meta_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_meta_reg <= scl_in;
            sda_meta_reg <= sda_in;
            scl_sync_reg <= scl_meta_reg;
            sda_sync_reg <= sda_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    assign scl_s = scl_sync_reg;
    assign sda_s = sda_sync_reg;
    assign scl_rise = scl_sync_reg & ~scl_prev_reg;
    assign scl_fall = ~scl_sync_reg & scl_prev_reg;
    // SDA change while SCL stays high
    assign start_det = scl_sync_reg & scl_prev_reg & sda_prev_reg &
        ~sda_sync_reg;
    assign stop_det = scl_sync_reg & scl_prev_reg & ~sda_prev_reg &
        sda_sync_reg;
endmodule

// ==== core/eep_prog_timer.v ====
// Self-timed programming cycle timer.
// Assumes a one-cycle start pulse from the slave logic.
`timescale 1ns/10ps
module eep_prog_timer #(
    parameter CYCLES = 100000,
    parameter CNT_W = 17
) (
    input wire mclk,
    input wire reset_n,
    input wire start,
    output wire busy
);
    localparam integer LAST_I = CYCLES - 1;
    localparam [CNT_W-1:0] LAST = LAST_I[CNT_W-1:0];
    reg [CNT_W-1:0] count_reg;
    reg busy_reg;

    // Busy for exactly CYCLES clocks after the start pulse
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_reg <= {CNT_W{1'b0}};
            busy_reg <= 1'b0;
        end else if (start && !busy_reg) begin
            count_reg <= {CNT_W{1'b0}};
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (count_reg == LAST) begin
                busy_reg <= 1'b0;
            end
            count_reg <= count_reg + 1'b1;
        end
    end

    assign busy = busy_reg;
endmodule

// ==== core/eep_slave.v ====
// Two-wire serial slave of a byte-wide nonvolatile memory array.
// Assumes pins are asynchronous to mclk and straps have pad pull-downs.
//
// Notes on behaviour
// - Programming ends within ten milliseconds after STOP.
// - While programming, SDA released, no address acknowledge.
// - SDA only pulled low or released.
// - Unconnected device select straps read as zero.
// - Write protect high blocks all programming.
// - SDA change with SCL high is condition.
// - START is SDA fall, SCL high; before ignored.
// - STOP is SDA rise while SCL high.
// - Address needs 1010 plus matching strap bits.
// - Address bit zero: one read, zero write.
// - Receiver acknowledges byte by low ninth clock.
// - Acknowledge own address and every unprotected written byte.
// - Read: eight bits, release, sample master acknowledge.
// - Byte write: address, two pointer bytes, data.
// - STOP after byte write starts programming, bus ignored.
// - Protected write: address acked, data byte not acked.
// - Pointer bits beyond array size are ignored.
`timescale 1ns/10ps
`include "eep_defs.vh"
module eep_slave #(
    parameter ADDR_W = `EEP_ADDR_W,
    parameter PROG_CYCLES = `EEP_PROG_TIME_MS * `EEP_CLK_KHZ,
    parameter TIMER_W = 17
) (
    input wire mclk,
    input wire reset_n,
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    input wire device_select_bit0,
    input wire device_select_bit1,
    input wire device_select_bit2,
    input wire wp_in,
    output wire prog_busy,
    output wire dev_selected
);
    localparam DEPTH = 1 << ADDR_W;

    // Slave states
    localparam [2:0] ST_IDLE = `EEP_ST_IDLE;
    localparam [2:0] ST_DEVADDR = `EEP_ST_DEVADDR;
    localparam [2:0] ST_ADDR_HI = `EEP_ST_ADDR_HI;
    localparam [2:0] ST_ADDR_LO = `EEP_ST_ADDR_LO;
    localparam [2:0] ST_WDATA = `EEP_ST_WDATA;
    localparam [2:0] ST_READ = `EEP_ST_READ;
    localparam [2:0] ST_WAITSTOP = `EEP_ST_WAITSTOP;

    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire busy;
    wire commit;
    wire addr_match;
    wire [`EEP_FULL_ADDR_W-1:0] full_addr;
    wire [7:0] rd_byte;

    reg [2:0] state_reg;
    reg [3:0] cnt_reg;
    reg ack_ph_reg;
    reg [7:0] shift_reg;
    reg sda_oe_reg;
    reg [ADDR_W-1:0] ptr_reg;
    reg [7:0] addr_hi_reg;
    reg [7:0] data_reg;
    reg data_ok_reg;
    reg [2:0] sel_meta_reg;
    reg [2:0] sel_sync_reg;
    reg wp_meta_reg;
    reg wp_sync_reg;
    reg [7:0] mem [0:DEPTH-1];

    eep_bus_sync u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    eep_prog_timer #(
        .CYCLES(PROG_CYCLES),
        .CNT_W(TIMER_W)
    ) u_timer (
        .mclk(mclk),
        .reset_n(reset_n),
        .start(commit),
        .busy(busy)
    );

    // Strap and write protect pins, two stages each
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sel_meta_reg <= 3'h0;
            sel_sync_reg <= 3'h0;
            wp_meta_reg <= 1'b0;
            wp_sync_reg <= 1'b0;
        end else begin
            // Pad pull-downs make open straps and WP read low
            sel_meta_reg <= {device_select_bit2, device_select_bit1,
                device_select_bit0};
            sel_sync_reg <= sel_meta_reg;
            wp_meta_reg <= wp_in;
            wp_sync_reg <= wp_meta_reg;
        end
    end

    // Byte just shifted in compared with the device address
    function match_addr;
        input [7:0] b;
        input [2:0] sel;
        begin
            match_addr = (b[`EEP_TYPE_MSB:`EEP_TYPE_LSB] == `EEP_TYPE_CODE)
                && (b[`EEP_SEL_MSB:`EEP_SEL_LSB] == sel);
        end
    endfunction

    // All bits of the current byte have been clocked
    function byte_done;
        input [3:0] c;
        begin
            byte_done = (c == `EEP_BYTE_BITS);
        end
    endfunction

    // Pointer step, wrapping at the array size
    function [ADDR_W-1:0] next_ptr;
        input [ADDR_W-1:0] p;
        begin
            next_ptr = p + 1'b1;
        end
    endfunction

    // Shift one bit in at the low end, MSB leaves first
    function [7:0] shift_in;
        input [7:0] b;
        input bit_in;
        begin
            shift_in = {b[`EEP_MSB-1:0], bit_in};
        end
    endfunction

    assign addr_match = match_addr(shift_reg, sel_sync_reg);
    assign full_addr = {addr_hi_reg, shift_reg};
    assign rd_byte = mem[ptr_reg];

    // Program only a complete, unprotected byte write
    assign commit = stop_det && !busy && (state_reg == ST_WDATA) &&
        data_ok_reg && !wp_sync_reg;

    always @(posedge mclk) begin
        if (commit) begin
            mem[ptr_reg] <= data_reg;
        end
    end

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `EEP_CNT_ZERO;
            ack_ph_reg <= 1'b0;
            shift_reg <= 8'h00;
            sda_oe_reg <= 1'b0;
            ptr_reg <= {ADDR_W{1'b0}};
            addr_hi_reg <= 8'h00;
            data_reg <= 8'h00;
            data_ok_reg <= 1'b0;
        end else if (busy) begin
            // Bus interface disabled while programming
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
            ack_ph_reg <= 1'b0;
            data_ok_reg <= 1'b0;
        end else if (start_det) begin
            state_reg <= ST_DEVADDR;
            cnt_reg <= `EEP_CNT_ZERO;
            ack_ph_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            data_ok_reg <= 1'b0;
        end else if (stop_det) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
            ack_ph_reg <= 1'b0;
            data_ok_reg <= 1'b0;
            if (commit) begin
                ptr_reg <= next_ptr(ptr_reg);
            end
        end else begin
            case (state_reg)
                ST_IDLE, ST_WAITSTOP: begin
                    // Wait for the next START
                    sda_oe_reg <= 1'b0;
                end
                ST_READ: begin
                    if (scl_fall && ack_ph_reg) begin
                        // Load next byte and drive its first bit
                        ack_ph_reg <= 1'b0;
                        cnt_reg <= `EEP_CNT_ZERO;
                        shift_reg <= rd_byte;
                        ptr_reg <= next_ptr(ptr_reg);
                        sda_oe_reg <= ~rd_byte[`EEP_MSB];
                    end else if (scl_rise && ack_ph_reg) begin
                        if (sda_s) begin
                            // No acknowledge: stop sending
                            state_reg <= ST_WAITSTOP;
                        end
                    end else if (scl_rise) begin
                        cnt_reg <= cnt_reg + 1'b1;
                    end else if (scl_fall) begin
                        if (byte_done(cnt_reg)) begin
                            // Release for the master acknowledge
                            ack_ph_reg <= 1'b1;
                            sda_oe_reg <= 1'b0;
                        end else begin
                            shift_reg <= shift_in(shift_reg, 1'b0);
                            sda_oe_reg <= ~shift_reg[`EEP_MSB-1];
                        end
                    end
                end
                default: begin
                    // Receive path: address, pointer and data bytes
                    if (scl_rise && !ack_ph_reg) begin
                        shift_reg <= shift_in(shift_reg, sda_s);
                        cnt_reg <= cnt_reg + 1'b1;
                    end else if (scl_fall && ack_ph_reg) begin
                        // End of ninth clock
                        ack_ph_reg <= 1'b0;
                        cnt_reg <= `EEP_CNT_ZERO;
                        sda_oe_reg <= 1'b0;
                    end else if (scl_fall &&
                        byte_done(cnt_reg)) begin
                        ack_ph_reg <= 1'b1;
                        case (state_reg)
                            ST_DEVADDR: begin
                                if (!addr_match) begin
                                    state_reg <= ST_WAITSTOP;
                                    sda_oe_reg <= 1'b0;
                                end else begin
                                    sda_oe_reg <= 1'b1;
                                    if (shift_reg[`EEP_RW_BIT]) begin
                                        state_reg <= ST_READ;
                                    end else begin
                                        state_reg <= ST_ADDR_HI;
                                    end
                                end
                            end
                            ST_ADDR_HI: begin
                                addr_hi_reg <= shift_reg;
                                sda_oe_reg <= 1'b1;
                                state_reg <= ST_ADDR_LO;
                            end
                            ST_ADDR_LO: begin
                                // High pointer bits past the array dropped
                                ptr_reg <= full_addr[ADDR_W-1:0];
                                sda_oe_reg <= 1'b1;
                                state_reg <= ST_WDATA;
                            end
                            ST_WDATA: begin
                                if (wp_sync_reg) begin
                                    // Protected: withhold acknowledge
                                    sda_oe_reg <= 1'b0;
                                    state_reg <= ST_WAITSTOP;
                                end else begin
                                    data_reg <= shift_reg;
                                    data_ok_reg <= 1'b1;
                                    sda_oe_reg <= 1'b1;
                                end
                            end
                            default: begin
                                state_reg <= ST_WAITSTOP;
                                sda_oe_reg <= 1'b0;
                            end
                        endcase
                    end
                end
            endcase
        end
    end

    // Open drain: the pin is only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_reg;
    assign prog_busy = busy;
    assign dev_selected = (state_reg != ST_IDLE) &&
        (state_reg != ST_WAITSTOP) &&
        (state_reg != ST_DEVADDR);
endmodule

// ==== dv/eep_slave_assertions.sv ====
// Concurrent checks on the serial memory slave pins.
// Assumes binding to eep_slave; pins reach the core two mclk late.
`timescale 1ns/10ps
module eep_slave_chk #(
    parameter PROG_CYCLES = 100000
) (
    input wire mclk,
    input wire reset_n,
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe,
    input wire device_select_bit0,
    input wire device_select_bit1,
    input wire device_select_bit2,
    input wire wp_in,
    input wire prog_busy,
    input wire dev_selected
);
    logic [31:0] busy_cnt;

    // Counts cycles of the current programming cycle
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt <= 32'h0;
        end else begin
            busy_cnt <= prog_busy ? busy_cnt + 32'h1 : 32'h0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    open_drain_a: assert property (!sda_out)
        else $error("sda data value not low");
    busy_release_a: assert property (prog_busy |-> !sda_oe)
        else $error("sda pulled during programming");
    busy_deaf_a: assert property (prog_busy |-> !dev_selected)
        else $error("selected during programming");
    prog_len_a: assert property (prog_busy |-> busy_cnt <= PROG_CYCLES)
        else $error("programming cycle too long");
    oe_scl_low_a: assert property
        ($changed(sda_oe) |-> !scl_in && !$past(scl_in, 2))
        else $error("sda drive changed near scl high");
    ack_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*6])
        else $error("sda low drive too short");
    stop_idle_a: assert property
        (scl_in && $rose(sda_in) |-> ##5 (!dev_selected && !sda_oe))
        else $error("not idle after stop");
    reset_quiet_a: assert property
        ($rose(reset_n) |-> (!sda_oe && !dev_selected) [*3])
        else $error("bus activity right after reset");
    wp_block_a: assert property ($rose(prog_busy) |-> !$past(wp_in, 3))
        else $error("programming while protected");
endmodule

bind eep_slave eep_slave_chk #(.PROG_CYCLES(PROG_CYCLES)) i_eep_slave_chk (
    .mclk(mclk),
    .reset_n(reset_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .device_select_bit0(device_select_bit0),
    .device_select_bit1(device_select_bit1),
    .device_select_bit2(device_select_bit2),
    .wp_in(wp_in),
    .prog_busy(prog_busy),
    .dev_selected(dev_selected)
);

// ==== dv/eep_bus_master.sv ====
// Two-wire bus master model driving the clock and open-drain data.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/10ps
module eep_bus_master (
    input wire mclk,
    input wire sda_line,
    output logic scl_o,
    output logic sda_low
);
    initial begin
        scl_o = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // One bit of 800 ns; data moves only while the clock is low
    task automatic bitx(input logic o, output logic i);
        wait_clk(1);
        sda_low = !o;
        wait_clk(3);
        scl_o = 1'b1;
        wait_clk(3);
        i = sda_line;
        wait_clk(1);
        scl_o = 1'b0;
    endtask

    task automatic start_c;
        wait_clk(1);
        sda_low = 1'b0;
        wait_clk(3);
        scl_o = 1'b1;
        wait_clk(4);
        sda_low = 1'b1;
        wait_clk(4);
        scl_o = 1'b0;
    endtask

    task automatic stop_c;
        wait_clk(1);
        sda_low = 1'b1;
        wait_clk(3);
        scl_o = 1'b1;
        wait_clk(4);
        sda_low = 1'b0;
        wait_clk(4);
    endtask

    task automatic tx(input logic [7:0] b, output logic nack);
        logic x;
        for (int j = 7; j >= 0; j--) begin
            bitx(b[j], x);
        end
        bitx(1'b1, nack);
    endtask

    task automatic rx(input logic nack, output logic [7:0] d);
        logic x;
        for (int j = 7; j >= 0; j--) begin
            bitx(1'b1, x);
            d[j] = x;
        end
        bitx(nack, x);
    endtask
endmodule

// ==== dv/eep_slave_tb.sv ====
// Self-checking bench for the serial memory slave.
// Assumes the bus master model and the bound pin checker.
`timescale 1ns/10ps
module eep_slave_tb;
    localparam int PROG = 200;
    logic mclk;
    logic reset_n;
    logic wp_in;
    logic [2:0] sel;
    wire scl, sda_low, sda_line, sda_out, sda_oe, prog_busy, dev_selected;
    int mismatches;
    int n_compared;
    int n;
    logic k;
    logic [7:0] d;

    assign sda_line = (sda_oe || sda_low) ? 1'b0 : 1'b1;

    eep_slave #(.PROG_CYCLES(PROG)) i_eep_slave (
        .mclk(mclk),
        .reset_n(reset_n),
        .scl_in(scl),
        .sda_in(sda_line),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .device_select_bit0(sel[0]),
        .device_select_bit1(sel[1]),
        .device_select_bit2(sel[2]),
        .wp_in(wp_in),
        .prog_busy(prog_busy),
        .dev_selected(dev_selected)
    );

    eep_bus_master i_eep_bus_master (
        .mclk(mclk),
        .sda_line(sda_line),
        .scl_o(scl),
        .sda_low(sda_low)
    );

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input string name, input logic [7:0] seen,
                         input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s exp %h seen %h", name, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic dev(input logic rd, input logic [2:0] s, input logic e);
        i_eep_bus_master.tx({4'ha, s, rd}, k);
        check("dev_ack", {7'h0, k}, {7'h0, e});
    endtask

    task automatic ptr(input logic [15:0] a);
        i_eep_bus_master.start_c;
        dev(1'b0, sel, 1'b0);
        i_eep_bus_master.tx(a[15:8], k);
        check("hi_ack", {7'h0, k}, 8'h0);
        i_eep_bus_master.tx(a[7:0], k);
        check("lo_ack", {7'h0, k}, 8'h0);
        check("sel_wr", {7'h0, dev_selected}, 8'h1);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic p);
        ptr(a);
        i_eep_bus_master.tx(v, k);
        check("data_ack", {7'h0, k}, {7'h0, p});
        i_eep_bus_master.stop_c;
    endtask

    task automatic rd2(input logic [15:0] a, input logic [7:0] e0,
                       input logic [7:0] e1);
        ptr(a);
        i_eep_bus_master.start_c;
        dev(1'b1, sel, 1'b0);
        i_eep_bus_master.rx(1'b0, d);
        check("rd_first", d, e0);
        i_eep_bus_master.rx(1'b1, d);
        check("rd_wrap", d, e1);
        i_eep_bus_master.stop_c;
        check("selected", {7'h0, dev_selected}, 8'h0);
    endtask

    task automatic wait_idle;
        n = 0;
        while (prog_busy !== 1'b0 && n < PROG + 50) begin
            @(negedge mclk);
            n++;
        end
        if (n >= PROG + 50) begin
            mismatches++;
            $display("[ERR] prog_busy exp 0 seen 1");
            results();
        end
    endtask

    initial begin
        reset_n = 1'b0;
        wp_in = 1'b0;
        sel = 3'h5;
        mismatches = 0;
        n_compared = 0;
        repeat (2) @(negedge mclk);
        reset_n = 1'b1;
        repeat (8) @(negedge mclk);
        wr(16'hffff, 8'h3c, 1'b0);
        check("busy", {7'h0, prog_busy}, 8'h1);
        wait_idle();
        check("prog_time", {7'h0, n <= PROG}, 8'h1);
        $display("test byte_write done");
        wr(16'h0000, 8'h5a, 1'b0);
        i_eep_bus_master.start_c;
        dev(1'b0, sel, 1'b1);
        i_eep_bus_master.stop_c;
        wait_idle();
        $display("test busy_poll done");
        rd2(16'h1fff, 8'h3c, 8'h5a);
        $display("test read_wrap done");
        i_eep_bus_master.start_c;
        dev(1'b0, 3'h2, 1'b1);
        i_eep_bus_master.tx(8'h00, k);
        check("ignored", {7'h0, k}, 8'h1);
        i_eep_bus_master.stop_c;
        $display("test mismatch done");
        wp_in = 1'b1;
        repeat (4) @(negedge mclk);
        wr(16'h0000, 8'hc3, 1'b1);
        check("wp_busy", {7'h0, prog_busy}, 8'h0);
        wp_in = 1'b0;
        rd2(16'h1fff, 8'h3c, 8'h5a);
        $display("test write_protect done");
        results();
    end
endmodule
